// ===== hw/mem_map_pkg.sv
// Package of constants and carriers for the memory map address decoder
package mem_map_pkg;
	localparam int          ADDR_W        = 24;
	localparam int          PAGE_W        = 8;
	localparam int          IDX_W         = 16;
	localparam int          EXT_ADDR_W    = 20;
	localparam int          NUM_BANKS     = 4;
	localparam int          RAM_DEPTH_W   = 12;
	localparam logic [7:0]  PAGE_INT      = 8'h00;
	localparam logic [7:0]  PAGE_ROM      = 8'hff;
	localparam logic [23:0] ROM_BASE      = 24'hff0000;
	localparam logic [7:0]  BANK1_RST     = 8'h40;
	localparam logic [7:0]  BANK2_RST     = 8'h80;
	localparam logic [7:0]  BANK3_RST     = 8'hc0;
	localparam logic [7:0]  BANK0_RST     = 8'h01;
	localparam logic [7:0]  IO_INT_LAST   = 8'h1f;
	localparam int          IO_OFS_W      = 10;
	localparam logic [23:0] BOOT_START_PC = ROM_BASE;
	// APB register byte addresses
	localparam logic [11:0] REG_DAG0_PAGE = 12'h000;
	localparam logic [11:0] REG_DAG1_PAGE = 12'h004;
	localparam logic [11:0] REG_JUMP_PAGE = 12'h008;
	localparam logic [11:0] REG_BANK_BND  = 12'h00c;
	localparam logic [11:0] REG_CFG_BANK  = 12'h010;
	localparam logic [11:0] REG_CFG_IO    = 12'h014;
	localparam logic [11:0] REG_CFG_BOOT  = 12'h018;
	localparam logic [11:0] REG_CLK_CTRL  = 12'h01c;
	localparam logic [11:0] REG_STATUS    = 12'h020;
	// Space configuration reset value: 16-bit wide, no waits
	localparam logic [15:0] CFG_RST       = 16'h8000;
	localparam int          CFG_WIDE_BIT  = 15;
	localparam logic [31:0] BND_RST       = 32'hc0804001;

	// Access request from core or DMA
	typedef enum logic [1:0] {
		SRC_DAG,
		SRC_DIRECT,
		SRC_JUMP,
		SRC_IO
	} addr_src_t;

	typedef struct packed {
		logic            valid;
		logic            dma;
		addr_src_t       src;
		logic            dag_sel;
		logic            boot;
		logic [15:0]     index;
		logic [23:0]     direct;
	} mem_req_t;

	typedef enum logic [2:0] {
		REG_INT_RAM0,
		REG_INT_RAM1,
		REG_BOOT_ROM,
		REG_EXT_BANK,
		REG_IO_INT,
		REG_IO_EXT,
		REG_BOOT_SPACE,
		REG_NONE
	} region_t;

	// Circular buffer address: wrap stays inside the page
	function automatic logic [15:0] circ_next(input logic [15:0] idx, input logic [15:0] mdf,
			input logic [15:0] base, input logic [15:0] len);
		logic [16:0] sum;
		logic [16:0] top;
		sum = {1'b0, idx} + {1'b0, mdf};
		top = {1'b0, base} + {1'b0, len};
		if (len == 16'h0000) begin
			circ_next = sum[15:0];
		end else if (!mdf[15] && sum >= top) begin
			circ_next = 16'(sum[15:0] - len);
		end else if (mdf[15] && sum[15:0] < base) begin
			circ_next = 16'(sum[15:0] + len);
		end else begin
			circ_next = sum[15:0];
		end
	endfunction
endpackage

// ===== hw/mem_map_decoder.sv
// Memory map address former, region decoder and external strobe driver
`timescale 1ns/1ps
module mem_map_decoder
	import mem_map_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire mem_req_t    req,
	input  wire logic        circ_en,
	input  wire logic [15:0] circ_mod,
	input  wire logic [15:0] circ_base,
	input  wire logic [15:0] circ_len,
	input  wire logic [23:0] int_wdata,
	input  wire logic        int_we,
	output logic      [23:0] int_rdata,
	output logic      [23:0] full_addr,
	output logic      [19:0] ext_addr,
	output logic             ext_byte_hi,
	output logic      [3:0]  bank_select_n,
	output logic             io_space_select_n,
	output logic             boot_space_select_n,
	output logic             int_hit,
	output logic             io_int_hit,
	output logic      [15:0] space_cfg,
	output logic      [23:0] fetch_pc,
	output logic             core_clk_out,
	output logic             periph_clk_en
);
	logic [7:0]  dag0_page_q;
	logic [7:0]  dag_second_page_reg_q;
	logic [7:0]  jump_page_reg_q;
	logic [31:0] bank_bnd_q;
	logic [15:0] cfg_bank_q;
	logic [15:0] cfg_io_q;
	logic [15:0] cfg_boot_q;
	logic        clk_half_q;
	logic        half_ph_q;
	logic [23:0] addr_d;
	logic [15:0] idx_eff;
	logic [7:0]  page;
	region_t     region_d;
	logic [1:0]  bank_d;
	logic [15:0] cfg_d;
	logic [23:0] ram0 [0:4095];
	logic [15:0] ram1 [0:4095];
	logic [23:0] rom  [0:4095];
	logic [31:0] rd_mux;
	logic        apb_acc;
	logic        mapped;
	region_t     region_q;

	assign apb_acc = psel && penable;

	// Circular buffer update keeps the page bits untouched
	always_comb begin
		idx_eff = circ_en ? circ_next(req.index, circ_mod, circ_base, circ_len) : req.index;
	end

	// Address formation from page registers, jump page or direct word
	always_comb begin
		case (req.src)
			SRC_DAG: begin
				page   = req.dag_sel ? dag_second_page_reg_q : dag0_page_q;
				addr_d = {page, idx_eff};
			end
			SRC_JUMP: begin
				page   = jump_page_reg_q;
				addr_d = {jump_page_reg_q, req.index};
			end
			SRC_DIRECT: begin
				page   = req.direct[23:16];
				addr_d = req.direct;
			end
			SRC_IO: begin
				page   = req.direct[17:10];
				addr_d = {6'h00, req.direct[17:0]};
			end
			default: begin
				page   = 8'h00;
				addr_d = 24'h000000;
			end
		endcase
	end

	// Region decode shared by core and DMA requesters
	always_comb begin
		bank_d   = 2'd0;
		region_d = REG_NONE;
		if (req.src == SRC_IO) begin
			region_d = (page <= IO_INT_LAST) ? REG_IO_INT : REG_IO_EXT;
		end else if (req.boot) begin
			region_d = REG_BOOT_SPACE;
		end else if (page == PAGE_INT) begin
			region_d = addr_d[RAM_DEPTH_W] ? REG_INT_RAM1 : REG_INT_RAM0;
		end else if (page == PAGE_ROM && addr_d >= ROM_BASE && !req.boot) begin
			region_d = REG_BOOT_ROM;
		end else begin
			region_d = REG_EXT_BANK;
			if (page >= bank_bnd_q[31:24]) begin
				bank_d = 2'd3;
			end else if (page >= bank_bnd_q[23:16]) begin
				bank_d = 2'd2;
			end else if (page >= bank_bnd_q[15:8]) begin
				bank_d = 2'd1;
			end else begin
				bank_d = 2'd0;
			end
		end
	end

	// Per-space configuration selection
	always_comb begin
		case (region_d)
			REG_IO_EXT:     cfg_d = cfg_io_q;
			REG_BOOT_SPACE: cfg_d = cfg_boot_q;
			default:        cfg_d = cfg_bank_q;
		endcase
	end

	// Registered strobes: one off-chip select at most, active low
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bank_select_n       <= 4'hf;
			io_space_select_n   <= 1'b1;
			boot_space_select_n <= 1'b1;
			region_q            <= REG_NONE;
		end else begin
			bank_select_n       <= 4'hf;
			io_space_select_n   <= 1'b1;
			boot_space_select_n <= 1'b1;
			region_q            <= req.valid ? region_d : REG_NONE;
			if (req.valid) begin
				case (region_d)
					REG_EXT_BANK:   bank_select_n[bank_d] <= 1'b0;
					REG_IO_EXT:     io_space_select_n     <= 1'b0;
					REG_BOOT_SPACE: boot_space_select_n   <= 1'b0;
					default:        bank_select_n         <= 4'hf;
				endcase
			end
		end
	end

	// External address: 16-bit port uses word address, 8-bit port a byte address
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			full_addr   <= 24'h000000;
			ext_addr    <= 20'h00000;
			ext_byte_hi <= 1'b0;
			space_cfg   <= CFG_RST;
			int_hit     <= 1'b0;
			io_int_hit  <= 1'b0;
		end else begin
			full_addr   <= addr_d;
			space_cfg   <= cfg_d;
			int_hit     <= req.valid && (region_d == REG_INT_RAM0 || region_d == REG_INT_RAM1
				|| region_d == REG_BOOT_ROM);
			io_int_hit  <= req.valid && region_d == REG_IO_INT;
			ext_byte_hi <= !cfg_d[CFG_WIDE_BIT];
			if (cfg_d[CFG_WIDE_BIT]) begin
				ext_addr <= addr_d[EXT_ADDR_W-1:0];
			end else begin
				ext_addr <= {addr_d[EXT_ADDR_W-2:0], 1'b0};
			end
		end
	end

	// Internal RAM and ROM storage, only the two RAM blocks are written here
	always_ff @(posedge mclk) begin
		if (req.valid && int_we && region_d == REG_INT_RAM0) begin
			ram0[addr_d[RAM_DEPTH_W-1:0]] <= int_wdata;
		end
		if (req.valid && int_we && region_d == REG_INT_RAM1) begin
			ram1[addr_d[RAM_DEPTH_W-1:0]] <= int_wdata[15:0];
		end
	end

	// Internal read data path
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			int_rdata <= 24'h000000;
		end else begin
			case (region_d)
				REG_INT_RAM0: int_rdata <= ram0[addr_d[RAM_DEPTH_W-1:0]];
				REG_INT_RAM1: int_rdata <= {8'h00, ram1[addr_d[RAM_DEPTH_W-1:0]]};
				REG_BOOT_ROM: int_rdata <= rom[addr_d[RAM_DEPTH_W-1:0]];
				default:      int_rdata <= 24'h000000;
			endcase
		end
	end

	// ROM write-once image port is not modelled; only rom[0] is cleared during reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			rom[0] <= 24'h000000;
		end
	end

	// Fetch start address after reset
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fetch_pc <= BOOT_START_PC;
		end else if (req.valid && req.src == SRC_DIRECT && !req.dma) begin
			fetch_pc <= req.direct;
		end
	end

	// Clock outputs: core clock toggles, peripheral enable every cycle or every other
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			core_clk_out  <= 1'b0;
			half_ph_q     <= 1'b0;
			periph_clk_en <= 1'b0;
		end else begin
			core_clk_out  <= !core_clk_out;
			half_ph_q     <= !half_ph_q;
			periph_clk_en <= clk_half_q ? half_ph_q : 1'b1;
		end
	end

	// APB register writes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dag0_page_q           <= PAGE_INT;
			dag_second_page_reg_q <= PAGE_INT;
			jump_page_reg_q       <= PAGE_INT;
			bank_bnd_q            <= BND_RST;
			cfg_bank_q            <= CFG_RST;
			cfg_io_q              <= CFG_RST;
			cfg_boot_q            <= CFG_RST;
			clk_half_q            <= 1'b1;
		end else if (apb_acc && pwrite) begin
			case (paddr)
				REG_DAG0_PAGE: dag0_page_q           <= pwdata[7:0];
				REG_DAG1_PAGE: dag_second_page_reg_q <= pwdata[7:0];
				REG_JUMP_PAGE: jump_page_reg_q       <= pwdata[7:0];
				REG_BANK_BND:  bank_bnd_q            <= pwdata;
				REG_CFG_BANK:  cfg_bank_q            <= pwdata[15:0];
				REG_CFG_IO:    cfg_io_q              <= pwdata[15:0];
				REG_CFG_BOOT:  cfg_boot_q            <= pwdata[15:0];
				REG_CLK_CTRL:  clk_half_q            <= pwdata[0];
				default:       clk_half_q            <= clk_half_q;
			endcase
		end
	end

	// APB read mux and decode of mapped offsets
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			REG_DAG0_PAGE: rd_mux = {24'h000000, dag0_page_q};
			REG_DAG1_PAGE: rd_mux = {24'h000000, dag_second_page_reg_q};
			REG_JUMP_PAGE: rd_mux = {24'h000000, jump_page_reg_q};
			REG_BANK_BND:  rd_mux = bank_bnd_q;
			REG_CFG_BANK:  rd_mux = {16'h0000, cfg_bank_q};
			REG_CFG_IO:    rd_mux = {16'h0000, cfg_io_q};
			REG_CFG_BOOT:  rd_mux = {16'h0000, cfg_boot_q};
			REG_CLK_CTRL:  rd_mux = {31'h00000000, clk_half_q};
			REG_STATUS:    rd_mux = {29'h00000000, region_q};
			default: begin
				rd_mux = 32'h00000000;
				mapped = 1'b0;
			end
		endcase
	end

	// APB answer: no wait cycle, ready and data registered from the setup phase
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
		end
	end
endmodule

// ===== verification/mem_map_checker.sv
// Concurrent checks on decoder strobes, addresses and boot state
`timescale 1ns/1ps
module mem_map_checker
	import mem_map_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset,
	input wire mem_req_t    req,
	input wire logic [23:0] full_addr,
	input wire logic [3:0]  bank_select_n,
	input wire logic        io_space_select_n,
	input wire logic        boot_space_select_n,
	input wire logic        io_int_hit,
	input wire logic [23:0] fetch_pc,
	input wire logic        core_clk_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Strobe group and request kinds
	wire [5:0] stb = {bank_select_n, io_space_select_n, boot_space_select_n};
	wire       dir = req.valid && !req.boot && req.src == SRC_DIRECT;
	wire       iop = req.valid && !req.boot && req.src == SRC_IO;
	chk_one_strobe: assert property ($countones(~stb) <= 1)
		else $error("two strobes low");
	chk_idle_quiet: assert property (!req.valid |=> stb == 6'h3f)
		else $error("strobe without request");
	chk_page0_int: assert property (dir && req.direct[23:16] == PAGE_INT |=> &bank_select_n)
		else $error("bank strobe on page zero");
	chk_rom_top: assert property (dir && req.direct[23:16] == PAGE_ROM |=> stb == 6'h3f)
		else $error("strobe on boot rom page");
	chk_direct_addr: assert property (dir |=> full_addr == $past(req.direct))
		else $error("direct address lost");
	chk_io_onchip: assert property (iop && req.direct[17:10] <= IO_INT_LAST |=>
		io_space_select_n && io_int_hit) else $error("low io page left chip");
	chk_io_offchip: assert property (iop && req.direct[17:10] > IO_INT_LAST |=>
		!io_space_select_n) else $error("high io page not selected");
	chk_boot_space: assert property (req.valid && req.boot |=> !boot_space_select_n)
		else $error("boot strobe missing");
	chk_boot_fetch: assert property ($fell(reset) |-> fetch_pc == BOOT_START_PC)
		else $error("fetch not at boot rom");
	chk_clk_toggle: assert property (!$past(reset) |-> core_clk_out != $past(core_clk_out))
		else $error("core clock stuck");
	// Main scenarios
	cover property (dir && req.direct[23:16] == 8'h40);
	cover property (iop ##1 !io_space_select_n);
	cover property (req.valid && req.boot);
endmodule

bind mem_map_decoder mem_map_checker u_chk (.mclk, .reset, .req, .full_addr, .bank_select_n,
	.io_space_select_n, .boot_space_select_n, .io_int_hit, .fetch_pc, .core_clk_out);

// ===== verification/ext_dev_model.sv
// External memory and peripheral side: counts selected cycles, answers by address
`timescale 1ns/1ps
module ext_dev_model (
	input  wire logic        mclk,
	input  wire logic [3:0]  bank_select_n,
	input  wire logic        io_space_select_n,
	input  wire logic        boot_space_select_n,
	input  wire logic [19:0] ext_addr,
	output logic      [15:0] rd_data,
	output int               sel_cnt
);
	initial sel_cnt = 0;
	initial rd_data = 16'h0000;
	// Unselected data lines toggle so a stale value never looks valid
	always @(posedge mclk) begin
		if (!(&bank_select_n && io_space_select_n && boot_space_select_n)) begin
			sel_cnt <= sel_cnt + 1;
			rd_data <= ext_addr[15:0];
		end else begin
			rd_data <= ~rd_data;
		end
	end
endmodule

// ===== verification/test_memory_map_address_decoder.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module test_memory_map_address_decoder;
	import mem_map_pkg::*;
	logic        mclk, reset, psel, penable, pwrite, pready, pslverr, er, vld_q;
	logic        io_space_select_n, boot_space_select_n, circ_en, int_we, wide;
	logic        ext_byte_hi, periph_clk_en, int_hit;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, bnd;
	logic [23:0] full_addr, fetch_pc, int_wdata, int_rdata, wv;
	logic [19:0] ext_addr;
	logic [15:0] space_cfg;
	logic [3:0]  bank_select_n;
	logic [7:0]  pg;
	logic [31:0] e;
	logic [31:0] q[$];
	// Bank space configuration used for the narrow-port pass
	localparam logic [15:0] CFG_NARROW = 16'h0005;
	logic [7:0]  pages [16] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h7f, 8'h80,
		8'h9f, 8'ha0, 8'hbf, 8'hc0, 8'hef, 8'hf0, 8'hfe, 8'hff};
	mem_req_t    req;
	int          error_cnt, cmp_count, ext_exp, sel_cnt, pn;

	mem_map_decoder uut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .req, .circ_en, .circ_mod(16'h0008), .circ_base(16'hfff0),
		.circ_len(16'h0010), .int_wdata, .int_we, .int_rdata, .full_addr, .ext_addr,
		.ext_byte_hi, .bank_select_n, .io_space_select_n, .boot_space_select_n, .int_hit,
		.io_int_hit(), .space_cfg, .fetch_pc, .core_clk_out(), .periph_clk_en);
	ext_dev_model model (.mclk, .bank_select_n, .io_space_select_n, .boot_space_select_n,
		.ext_addr, .rd_data(), .sel_cnt);

	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One request cycle; the expected strobes and address go on the queue
	task automatic rq(input addr_src_t s, input logic b, input logic [23:0] d,
		input logic [7:0] p, input logic c = 1'b0, input logic [15:0] ci = 16'h0000);
		logic [5:0] sv;
		sv = 6'h3f;
		if (b) sv[0] = 1'b0;
		else if (s == SRC_IO) sv[1] = (p <= IO_INT_LAST);
		else if (p != PAGE_INT && p != PAGE_ROM) sv[5:2] = p >= bnd[31:24] ? 4'h7 :
			p >= bnd[23:16] ? 4'hb : p >= bnd[15:8] ? 4'hd : 4'he;
		if (sv != 6'h3f) ext_exp++;
		q.push_back({wide, !(b || s == SRC_IO), sv, (s == SRC_DAG || s == SRC_JUMP) ?
			{p, c ? ci : d[15:0]} : d});
		@(posedge mclk);
		req <= '{valid: 1'b1, dma: 1'($urandom), src: s, dag_sel: 1'b1, boot: b,
			index: d[15:0], direct: d};
		circ_en <= c;
		int_wdata <= 24'($urandom);
	endtask

	// Result monitor, one cycle after each sampled request
	always @(posedge mclk) vld_q <= req.valid;
	always @(negedge mclk) begin
		if (vld_q && q.size() > 0) begin
			e = q.pop_front();
			if (e[30]) begin
				chk("map", {2'b00, bank_select_n, io_space_select_n, boot_space_select_n,
					full_addr}, {2'b00, e[29:0]});
				chk("ext", {11'h000, ext_byte_hi, ext_addr},
					{11'h000, !e[31], e[31] ? e[19:0] : {e[18:0], 1'b0}});
				chk("cfg", {16'h0000, space_cfg},
					{16'h0000, e[31] ? CFG_RST : CFG_NARROW});
			end else begin
				chk("space", {26'h0, bank_select_n, io_space_select_n, boot_space_select_n},
					{26'h0, e[29:24]});
			end
		end
	end

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Watchdog
	initial begin
		#100000;
		error_cnt++;
		conclude;
	end

	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, int_wdata, circ_en, int_we} = '0;
		wide = 1'b1;
		req = '0;
		bnd = BND_RST;
		void'($urandom(32'h2f23));
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		chk("reset", {2'b00, bank_select_n, io_space_select_n, boot_space_select_n, fetch_pc},
			{2'b00, 6'h3f, BOOT_START_PC});
		apb(1'b0, REG_BANK_BND, 32'h0);
		chk("bounds", rd, BND_RST);
		apb(1'b0, REG_CFG_BANK, 32'h0);
		chk("config", rd, {16'h0000, CFG_RST});
		apb(1'b0, 12'h0fc, 32'h0);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		pg = 8'($urandom_range(254, 1));
		apb(1'b1, REG_DAG1_PAGE, {24'h0, pg});
		apb(1'b1, REG_JUMP_PAGE, {24'h0, ~pg});
		// Peripheral enable after reset runs at half rate
		pn = 0;
		repeat (8) begin
			@(posedge mclk);
			pn += periph_clk_en;
		end
		chk("half rate", pn, 4);
		for (int r = 0; r < 2; r++) begin
			foreach (pages[i]) rq(SRC_DIRECT, 1'b0, {pages[i], 16'($urandom)}, pages[i]);
			rq(SRC_DAG, 1'b0, 24'($urandom), pg);
			rq(SRC_DAG, 1'b0, {8'h00, 16'hfffc}, pg, 1'b1, 16'hfff4);
			rq(SRC_JUMP, 1'b0, 24'($urandom), ~pg);
			rq(SRC_IO, 1'b0, {6'h0, 8'h1f, 10'($urandom)}, 8'h1f);
			rq(SRC_IO, 1'b0, {6'h0, 8'h20, 10'($urandom)}, 8'h20);
			rq(SRC_IO, 1'b0, {6'h0, 8'hff, 10'($urandom)}, 8'hff);
			rq(SRC_DIRECT, 1'b1, 24'($urandom), 8'h00);
			@(posedge mclk);
			req.valid <= 1'b0;
			bnd = 32'hf0a02001;
			apb(1'b1, REG_BANK_BND, bnd);
			apb(1'b0, REG_BANK_BND, 32'h0);
			chk("new bounds", rd, bnd);
			apb(1'b1, REG_CFG_BANK, {16'h0000, CFG_NARROW});
			wide = 1'b0;
		end
		// Internal RAM blocks: write a word into each, read it back one cycle later
		for (int b = 0; b < 2; b++) begin
			wv = 24'($urandom);
			@(posedge mclk);
			req <= '{valid: 1'b1, dma: 1'b0, src: SRC_DIRECT, dag_sel: 1'b0, boot: 1'b0,
				index: 16'h0000, direct: {11'h000, b[0], 12'h5a5}};
			int_we <= 1'b1;
			int_wdata <= wv;
			@(posedge mclk);
			int_we <= 1'b0;
			@(posedge mclk);
			@(negedge mclk);
			chk("ram", {7'h00, int_hit, int_rdata}, {8'h01, b ? {8'h00, wv[15:0]} : wv});
		end
		@(posedge mclk);
		req.valid <= 1'b0;
		// I/O and boot space keep their own configuration words
		apb(1'b1, REG_CFG_IO, 32'h00001234);
		apb(1'b1, REG_CFG_BOOT, 32'h00000042);
		apb(1'b0, REG_CFG_IO, 32'h0);
		chk("io config", rd, 32'h00001234);
		apb(1'b0, REG_CFG_BOOT, 32'h0);
		chk("boot config", rd, 32'h00000042);
		// Full-rate peripheral enable pulses every cycle
		apb(1'b1, REG_CLK_CTRL, 32'h0);
		@(posedge mclk);
		pn = 0;
		repeat (8) begin
			@(posedge mclk);
			pn += periph_clk_en;
		end
		chk("full rate", pn, 8);
		repeat (4) @(posedge mclk);
		chk("selects", sel_cnt, ext_exp);
		chk("pending", q.size(), 0);
		conclude;
	end
endmodule
